/* File: design/ioe_consts.svh */
`ifndef IOE_CONSTS_SVH
`define IOE_CONSTS_SVH
// ==========================================================
// Address, class codes and timing counts
`define IOE_ADDR_FIXED  3'h5
`define IOE_PAD_SCL     2'h0
`define IOE_PAD_SDA     2'h1
`define IOE_PAD_GND     2'h2
`define IOE_PAD_VPLUS   2'h3
`define IOE_GRP_HI      4'hF
`define IOE_GRP_LO      4'h0
`define IOE_LO_FLIP     2'h2
`define IOE_BIT_LAST    3'h7
`define IOE_BIT_FIRST   3'h0
`define IOE_BIT_STEP    3'h1
`define IOE_INIT_WAIT   2'h3
`define IOE_INIT_STEP   2'h1
`define IOE_INIT_ZERO   2'h0
`define IOE_BYTE_ZERO   8'h00
`define IOE_NIB_ZERO    4'h0
// ==========================================================
// Link state codes, Gray along the usual path
`define IOE_ST_IDLE     3'h0
`define IOE_ST_ADDR     3'h1
`define IOE_ST_ACK_A    3'h3
`define IOE_ST_WR       3'h2
`define IOE_ST_ACK_W    3'h6
`define IOE_ST_RD       3'h7
`define IOE_ST_MACK     3'h5
`endif

/* File: design/ioe_pkg.sv */
`include "ioe_consts.svh"
package ioe_pkg;
  // ==========================================================
  // Classification of one address select pad
  typedef enum logic [1:0] {
    ioe_pad_scl   = `IOE_PAD_SCL,
    ioe_pad_sda   = `IOE_PAD_SDA,
    ioe_pad_gnd   = `IOE_PAD_GND,
    ioe_pad_vplus = `IOE_PAD_VPLUS
  } ioe_pad_class_t;

  // ==========================================================
  // Serial engine states
  typedef enum logic [2:0] {
    ioe_st_idle  = `IOE_ST_IDLE,
    ioe_st_addr  = `IOE_ST_ADDR,
    ioe_st_ack_a = `IOE_ST_ACK_A,
    ioe_st_wr    = `IOE_ST_WR,
    ioe_st_ack_w = `IOE_ST_ACK_W,
    ioe_st_rd    = `IOE_ST_RD,
    ioe_st_mack  = `IOE_ST_MACK
  } ioe_state_t;

  // ==========================================================
  // Evidence gathered about a pad during one frame
  typedef struct packed {
    logic saw_hi;
    logic saw_lo;
    logic diff_sda;
    logic diff_scl;
  } ioe_evid_t;

  // ==========================================================
  // Slow pins as seen in the system domain
  typedef struct packed {
    logic clear_n;
    logic scl;
    logic sda;
    logic pad_hi;
    logic pad_lo;
  } ioe_pins_t;
endpackage

/* File: design/ioe_sync2.sv */
`timescale 1ns/1ns
// ==========================================================
// Two stage synchroniser, first stage feeds only the second
module ioe_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         srst,  // Synchronous reset
  input  wire logic [W-1:0] d,     // Asynchronous input
  output logic      [W-1:0] q      // Synchronised output
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ==========================================================
  // Next values
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule

/* File: design/ioe_pad_class.sv */
`timescale 1ns/1ns
`include "ioe_consts.svh"
// ==========================================================
// Classifies one address select pad against bus activity
module ioe_pad_class (
  input  wire logic                    clk,          // System clock
  input  wire logic                    srst,         // Synchronous reset
  input  wire logic                    frame_start,  // Start seen, one cycle
  input  wire logic                    frame_on,     // Frame in progress
  input  wire logic                    pad,          // Synchronised pad level
  input  wire logic                    scl,          // Synchronised clock line
  input  wire logic                    sda,          // Synchronised data line
  output ioe_pkg::ioe_pad_class_t      pad_class     // Current classification
);
  import ioe_pkg::*;

  ioe_evid_t      ev;
  ioe_evid_t      next_ev;
  logic           seen;
  logic           next_seen;
  ioe_pad_class_t next_pad_class;

  // ==========================================================
  // Evidence resets at each start so every frame re-decides
  always_comb begin
    next_ev   = ev;
    next_seen = seen;
    if (frame_start) begin
      next_ev   = '0;
      next_seen = 1'b1;
    end else if (frame_on) begin
      next_ev.saw_hi   = ev.saw_hi | pad;
      next_ev.saw_lo   = ev.saw_lo | ~pad;
      next_ev.diff_sda = ev.diff_sda | (pad ^ sda);  // [R4]
      next_ev.diff_scl = ev.diff_scl | (pad ^ scl);  // [R4]
    end
    // Before any frame only a level can be told apart
    if (!seen) begin
      next_pad_class = pad ? ioe_pad_vplus : ioe_pad_gnd;  // [R5]
    end else if (ev.saw_hi && ev.saw_lo && !ev.diff_sda) begin
      next_pad_class = ioe_pad_sda;  // [R2]
    end else if (ev.saw_hi && ev.saw_lo && !ev.diff_scl) begin
      next_pad_class = ioe_pad_scl;  // [R2]
    end else if (ev.saw_hi) begin
      next_pad_class = ioe_pad_vplus;
    end else begin
      next_pad_class = ioe_pad_gnd;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ev        <= '0;
      seen      <= 1'b0;
      pad_class <= ioe_pad_gnd;
    end else begin
      ev        <= next_ev;
      seen      <= next_seen;
      pad_class <= next_pad_class;
    end
  end
endmodule

/* File: design/ioe_expander.sv */
`timescale 1ns/1ns
`include "ioe_consts.svh"
// ==========================================================
// Summary of operation
// R1 - Answer only addresses whose top three bits are one, zero, one.
// R2 - High select gives address bits 3..2, low select gives bits 1..0.
// R3 - Address is decided again on every transmission, whoever it targets.
// R4 - Select pads are compared with data and clock lines during a frame.
// R5 - Before the first frame a select pad reads only as high or low.
// R6 - Low select sets outputs 3..0 default, high select outputs 7..4.
// R7 - Group defaults high for high or bus-tied select, low for low.
// R8 - Bus clear abandons any transaction and returns link to idle.
// R9 - Bus clear leaves output register and driven outputs untouched.
// R10 - Reads return real pin levels, not the output register.
// R11 - Bus-tied select seen low at power-up gives wrong defaults till a byte is written.
// R12 - Standby whenever the link is idle, left when activity resumes.
// R13 - Each written byte updates all eight outputs and is acknowledged.
// R14 - Pin levels are sampled in each acknowledge bit of a read.
// R15 - Byte bit seven maps to output seven, bit zero to output zero.
// R16 - Defaults are loaded in the same cycle as the outputs are enabled.
module ioe_expander (
  input  wire logic       clk,                     // System clock
  input  wire logic       srst,                    // Synchronous reset
  input  wire logic       scl_clk,                 // Link clock from master
  input  wire logic       scl_level,               // Same line, as data
  input  wire logic       sda_in,                  // Data line level
  output logic            sda_out,                 // Data line drive value
  output logic            sda_oe,                  // Data line pull low
  input  wire logic       low_group_addr_select,   // Low select pad
  input  wire logic       high_group_addr_select,  // High select pad
  input  wire logic       bus_clear_n,             // Bus clear pin
  input  wire logic [7:0] pin_level,               // Readback of outputs
  output logic      [7:0] push_pull_outputs,       // Output levels
  output logic            push_pull_oe,            // Outputs driven
  output logic            standby                  // Link idle
);
  import ioe_pkg::*;

  // ==========================================================
  // System domain signals
  ioe_pins_t      pins_raw;
  ioe_pins_t      pins_s;
  ioe_pad_class_t lo_class;
  ioe_pad_class_t hi_class;
  logic           sda_prev;
  logic           next_sda_prev;
  logic           bus_start;
  logic           bus_stop;
  logic           frame_on;
  logic           next_frame_on;
  logic           link_rst;
  logic           next_link_rst;
  logic           line_idle;
  logic           next_line_idle;
  logic           next_standby;
  logic [1:0]     init_cnt;
  logic [1:0]     next_init_cnt;
  logic           next_oe;
  logic [7:0]     next_outputs;
  logic           wtog_s1;
  logic           wtog_s2;
  logic           wtog_s3;
  logic [3:0]     addr_pub;
  logic [3:0]     next_addr_pub;
  logic           ptog;
  logic           next_ptog;

  // ==========================================================
  // Link domain signals
  ioe_state_t     state;
  ioe_state_t     next_state;
  logic [2:0]     cnt;
  logic [2:0]     next_cnt;
  logic [7:0]     shreg;
  logic [7:0]     next_shreg;
  logic [7:0]     tx;
  logic [7:0]     next_tx;
  logic           rw;
  logic           next_rw;
  logic           next_sda_oe;
  logic [7:0]     wr_data;
  logic [7:0]     next_wr_data;
  logic           wtog;
  logic           next_wtog;
  logic           ptog_s1;
  logic           ptog_s2;
  logic           ptog_s3;
  logic [3:0]     addr_link;
  logic [3:0]     next_addr_link;
  logic           sda_hi;
  logic [7:0]     rb_s1;
  logic [7:0]     rb_s2;
  logic [7:0]     rb_cap;
  logic [7:0]     next_rb_cap;
  logic           link_start;
  logic           link_stop;

  // ==========================================================
  // Pin synchronisers into the system domain
  assign pins_raw = '{clear_n: bus_clear_n, scl: scl_level, sda: sda_in,
                      pad_hi: high_group_addr_select,
                      pad_lo: low_group_addr_select};

  ioe_sync2 #(
    .W ($bits(ioe_pins_t))
  ) u_pin_sync (
    .clk  (clk),
    .srst (srst),
    .d    (pins_raw),
    .q    (pins_s)
  );

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;

  // ==========================================================
  // Start and stop as seen by the system domain
  assign bus_start = pins_s.scl & sda_prev & ~pins_s.sda;
  assign bus_stop  = pins_s.scl & ~sda_prev & pins_s.sda;

  // ==========================================================
  // Pad classification, one per select pad
  ioe_pad_class u_lo_class (
    .clk         (clk),
    .srst        (srst),
    .frame_start (bus_start),   // [R3]
    .frame_on    (frame_on),
    .pad         (pins_s.pad_lo),
    .scl         (pins_s.scl),
    .sda         (pins_s.sda),
    .pad_class   (lo_class)
  );

  ioe_pad_class u_hi_class (
    .clk         (clk),
    .srst        (srst),
    .frame_start (bus_start),   // [R3]
    .frame_on    (frame_on),
    .pad         (pins_s.pad_hi),
    .scl         (pins_s.scl),
    .sda         (pins_s.sda),
    .pad_class   (hi_class)
  );

  // ==========================================================
  // Frame tracking, bus clear, standby and address publishing
  always_comb begin
    next_sda_prev = pins_s.sda;
    next_link_rst = ~pins_s.clear_n;  // [R8]
    next_line_idle = ~pins_s.clear_n | bus_stop;  // [R8]
    next_frame_on = frame_on;
    if (!pins_s.clear_n) begin
      next_frame_on = 1'b0;           // [R8]
    end else if (bus_start) begin
      next_frame_on = 1'b1;
    end else if (bus_stop) begin
      next_frame_on = 1'b0;
    end
    next_standby  = ~next_frame_on;   // [R12]
    // Word goes out with a toggle; low pad codes run GND, V+, SCL, SDA
    next_addr_pub = {hi_class, lo_class ^ `IOE_LO_FLIP};  // [R2]
    next_ptog     = ptog;
    if (next_addr_pub != addr_pub) begin
      next_ptog = ~ptog;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_prev <= 1'b1;
      link_rst <= 1'b1;
      line_idle <= 1'b1;
      frame_on <= 1'b0;
      standby  <= 1'b1;
      addr_pub <= {`IOE_PAD_GND, `IOE_PAD_GND};
      ptog     <= 1'b0;
    end else begin
      sda_prev <= next_sda_prev;
      link_rst <= next_link_rst;
      line_idle <= next_line_idle;
      frame_on <= next_frame_on;
      standby  <= next_standby;
      addr_pub <= next_addr_pub;
      ptog     <= next_ptog;
    end
  end

  // ==========================================================
  // Output register: defaults at power-up, then written bytes
  always_comb begin
    next_init_cnt = init_cnt;
    next_oe       = push_pull_oe;
    next_outputs  = push_pull_outputs;
    if (!push_pull_oe) begin
      // Waits for the pad synchronisers to fill before trusting them
      if (init_cnt == `IOE_INIT_WAIT) begin
        next_outputs[7:4] = pins_s.pad_hi ? `IOE_GRP_HI : `IOE_GRP_LO;  // [R6] [R7] [R11]
        next_outputs[3:0] = pins_s.pad_lo ? `IOE_GRP_HI : `IOE_GRP_LO;  // [R6] [R7] [R11]
        next_oe           = 1'b1;  // [R16]
      end else begin
        next_init_cnt = init_cnt + `IOE_INIT_STEP;
      end
    end else if (wtog_s3 != wtog_s2 && !link_rst) begin  // Reset-made toggle is no write [R9]
      next_outputs = wr_data;  // [R13] [R15]
    end
  end

  // Registers; bus clear is not a reset here, so outputs hold
  always_ff @(posedge clk) begin
    if (srst) begin
      init_cnt          <= `IOE_INIT_ZERO;
      push_pull_oe      <= 1'b0;
      push_pull_outputs <= `IOE_BYTE_ZERO;
      wtog_s1           <= 1'b0;
      wtog_s2           <= 1'b0;
      wtog_s3           <= 1'b0;
    end else begin
      init_cnt          <= next_init_cnt;
      push_pull_oe      <= next_oe;
      push_pull_outputs <= next_outputs;  // [R9]
      wtog_s1           <= wtog;
      wtog_s2           <= wtog_s1;
      wtog_s3           <= wtog_s2;
    end
  end

  // ==========================================================
  // Link domain, rising edge: data bit and readback sampling
  always_comb begin
    next_rb_cap = rb_cap;
    if ((state == ioe_st_ack_a && rw) || state == ioe_st_mack) begin
      next_rb_cap = rb_s2;  // [R10] [R14]
    end
  end

  // Registers
  always_ff @(posedge scl_clk or posedge line_idle) begin  // Stop re-arms start detection
    if (line_idle) begin
      sda_hi <= 1'b1;
      rb_s1  <= `IOE_BYTE_ZERO;
      rb_s2  <= `IOE_BYTE_ZERO;
      rb_cap <= `IOE_BYTE_ZERO;
    end else begin
      sda_hi <= sda_in;
      rb_s1  <= pin_level;
      rb_s2  <= rb_s1;
      rb_cap <= next_rb_cap;
    end
  end

  // ==========================================================
  // Link domain, falling edge: protocol engine
  // Data changing in a high phase marks start or stop
  assign link_start = sda_hi & ~sda_in;
  assign link_stop  = ~sda_hi & sda_in;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_tx        = tx;
    next_rw        = rw;
    next_sda_oe    = sda_oe;
    next_wr_data   = wr_data;
    next_wtog      = wtog;
    next_addr_link = addr_link;
    if (ptog_s3 == ptog_s2 && ptog_s2 == ptog_s1) begin  // No toggle in flight
      next_addr_link = addr_pub;  // [R3]
    end
    if (link_start) begin
      next_state  = ioe_st_addr;
      next_cnt    = `IOE_BIT_FIRST;
      next_sda_oe = 1'b0;
    end else if (link_stop) begin
      next_state  = ioe_st_idle;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ioe_st_addr: begin
          next_shreg = {shreg[6:0], sda_hi};
          next_cnt   = cnt + `IOE_BIT_STEP;
          if (cnt == `IOE_BIT_LAST) begin
            if (shreg[6:0] == {`IOE_ADDR_FIXED, addr_link}) begin  // [R1] [R2]
              next_rw     = sda_hi;
              next_sda_oe = 1'b1;
              next_state  = ioe_st_ack_a;
            end else begin
              next_state = ioe_st_idle;
            end
          end
        end
        ioe_st_ack_a: begin
          next_cnt = `IOE_BIT_FIRST;
          if (rw) begin
            next_tx     = rb_cap;      // [R10]
            next_sda_oe = ~rb_cap[7];  // [R15]
            next_state  = ioe_st_rd;
          end else begin
            next_sda_oe = 1'b0;
            next_state  = ioe_st_wr;
          end
        end
        ioe_st_wr: begin
          next_shreg = {shreg[6:0], sda_hi};
          next_cnt   = cnt + `IOE_BIT_STEP;
          if (cnt == `IOE_BIT_LAST) begin
            next_wr_data = {shreg[6:0], sda_hi};  // [R13] [R15]
            next_wtog    = ~wtog;
            next_sda_oe  = 1'b1;                  // [R13]
            next_state   = ioe_st_ack_w;
          end
        end
        ioe_st_ack_w: begin
          next_sda_oe = 1'b0;
          next_cnt    = `IOE_BIT_FIRST;
          next_state  = ioe_st_wr;
        end
        ioe_st_rd: begin
          next_cnt = cnt + `IOE_BIT_STEP;
          next_tx  = {tx[6:0], 1'b0};
          if (cnt == `IOE_BIT_LAST) begin
            next_sda_oe = 1'b0;
            next_state  = ioe_st_mack;
          end else begin
            next_sda_oe = ~tx[6];
          end
        end
        ioe_st_mack: begin
          next_cnt = `IOE_BIT_FIRST;
          if (!sda_hi) begin
            next_tx     = rb_cap;      // [R14]
            next_sda_oe = ~rb_cap[7];
            next_state  = ioe_st_rd;
          end else begin
            next_state = ioe_st_idle;
          end
        end
        default: begin
          next_sda_oe = 1'b0;
          next_state  = ioe_st_idle;
        end
      endcase
    end
  end

  // Registers; bus clear drops the engine to idle at once
  always_ff @(negedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      state     <= ioe_st_idle;  // [R8]
      cnt       <= `IOE_BIT_FIRST;
      shreg     <= `IOE_BYTE_ZERO;
      tx        <= `IOE_BYTE_ZERO;
      rw        <= 1'b0;
      sda_oe    <= 1'b0;         // [R8]
      wr_data   <= `IOE_BYTE_ZERO;
      wtog      <= 1'b0;
      ptog_s1   <= 1'b0;
      ptog_s2   <= 1'b0;
      ptog_s3   <= 1'b0;
      addr_link <= `IOE_NIB_ZERO;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      tx        <= next_tx;
      rw        <= next_rw;
      sda_oe    <= next_sda_oe;
      wr_data   <= next_wr_data;
      wtog      <= next_wtog;
      ptog_s1   <= ptog;
      ptog_s2   <= ptog_s1;
      ptog_s3   <= ptog_s2;
      addr_link <= next_addr_link;
    end
  end
endmodule

/* File: dv/ioe_expander_sva.sv */
`timescale 1ns/1ns
// ==========================================================
// Expander port checks
module ioe_expander_sva (
  input wire logic       clk,                     // System clock
  input wire logic       srst,                    // Synchronous reset
  input wire logic       scl_level,               // Clock line level
  input wire logic       sda_in,                  // Data line level
  input wire logic       sda_oe,                  // Data pull low
  input wire logic       low_group_addr_select,   // Low select pad
  input wire logic       high_group_addr_select,  // High select pad
  input wire logic       bus_clear_n,             // Bus clear
  input wire logic [7:0] push_pull_outputs,       // Output levels
  input wire logic       push_pull_oe,            // Outputs driven
  input wire logic       standby                  // Link idle
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ==========================================================
  // Bus events
  sequence s_start;
    scl_level && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_level && $rose(sda_in);
  endsequence
  sequence s_clear_held;
    (!bus_clear_n)[*4];
  endsequence

  // ==========================================================
  // Assertions
  chk_start_wakes: assert property (s_start |-> ##[1:8] !standby)
    else $error("standby still high after start");
  chk_stop_idles: assert property (s_stop |-> ##[1:12] standby)
    else $error("standby not back after stop");
  chk_clear_frees: assert property (s_clear_held |-> !sda_oe && standby)
    else $error("bus clear left the link busy");
  chk_clear_keeps: assert property ((!bus_clear_n)[*6] |->
    $stable(push_pull_outputs) && $stable(push_pull_oe))
    else $error("bus clear disturbed the outputs");
  chk_oe_stays: assert property (push_pull_oe |=> push_pull_oe)
    else $error("output enable dropped");
  chk_reset_quiet: assert property ($fell(srst) |-> !push_pull_oe &&
    push_pull_outputs == 8'h00 && standby && !sda_oe)
    else $error("wrong state at reset release");
  chk_oe_timing: assert property ($fell(srst) |->
    (!push_pull_oe)[*3] ##[1:2] push_pull_oe)
    else $error("output enable late or early");
  chk_defaults_load: assert property ($rose(push_pull_oe) |->
    push_pull_outputs == {{4{high_group_addr_select}}, {4{low_group_addr_select}}})
    else $error("wrong default levels");
  // Clear window left out
  chk_drive_in_low: assert property (bus_clear_n && $past(bus_clear_n, 4) &&
    $changed(sda_oe) |-> !scl_level)
    else $error("data drive changed while clock high");
endmodule

/* File: dv/ioe_i2c_master.sv */
`timescale 1ns/1ns
// ==========================================================
// Bus master model; clock line stands high between frames
module ioe_i2c_master (
  output logic      scl = 1'b1,       // Clock line
  output logic      sda_pull = 1'b0,  // High pulls data low
  input  wire logic sda        // Resolved data line
);
  // One bit: data moves in the low phase, read mid high phase
  task automatic send_bit(input logic b, output logic r);
    sda_pull = !b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask
  // Start
  task automatic bus_start();
    sda_pull = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask
  // Stop
  task automatic bus_stop();
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #32;
  endtask
  // Byte out, MSB first, then ack slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i], r);
    end
    send_bit(1'b1, r);
    ack = !r; // Receiver pulls low
  endtask
  // Byte in, then master ack or nack
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic r;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      send_bit(1'b1, r);
      b = {b[6:0], r};
    end
    send_bit(!mack, r);
  endtask
endmodule

/* File: dv/ioe_expander_bench.sv */
`timescale 1ns/1ns
module ioe_expander_bench;
  import ioe_pkg::*;
  logic           clk, srst, bus_clear_n, sda_out, sda_oe, oe, standby, pin_force_en;
  logic     [7:0] outs, pin_force;
  wire      [7:0] pin_level = pin_force_en ? pin_force : outs;
  wire            scl, m_pull;
  wire            sda = !(m_pull || sda_oe);  // Pull-up on data line
  ioe_pad_class_t hi_tie, lo_tie;
  wire            hi_pad = tie_level(hi_tie);
  wire            lo_pad = tie_level(lo_tie);
  int             mismatches, num_checks, cycles;

  // ==========================================================
  // Clock, instances and helpers
  always #5 clk = ~clk;
  ioe_expander ioe_expander_inst (.clk, .srst, .scl_clk(scl), .scl_level(scl), .sda_in(sda),
    .sda_out, .sda_oe, .low_group_addr_select(lo_pad), .high_group_addr_select(hi_pad),
    .bus_clear_n, .pin_level, .push_pull_outputs(outs), .push_pull_oe(oe), .standby);
  ioe_i2c_master ioe_i2c_master_inst (.scl(scl), .sda_pull(m_pull), .sda(sda));

  // Pad tie level
  function automatic logic tie_level(ioe_pad_class_t c);
    case (c)
      ioe_pad_scl: return scl;
      ioe_pad_sda: return sda;
      ioe_pad_gnd: return 1'b0;
      default:     return 1'b1;
    endcase
  endfunction
  // Low pad address bits; high pad bits equal the class code
  function automatic logic [1:0] lo_bits(ioe_pad_class_t c);
    case (c)
      ioe_pad_gnd:   return 2'h0;
      ioe_pad_vplus: return 2'h1;
      ioe_pad_scl:   return 2'h2;
      default:       return 2'h3;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One-byte write frame
  task automatic write1(input logic [6:0] a, input logic [7:0] d, output logic aa, da);
    ioe_i2c_master_inst.bus_start();
    ioe_i2c_master_inst.put_byte({a, 1'b0}, aa);
    ioe_i2c_master_inst.put_byte(d, da);
    ioe_i2c_master_inst.bus_stop();
    tick(8);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_powerup(input ioe_pad_class_t h, l, input logic [7:0] exp);
    hi_tie = h;
    lo_tie = l;
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(12);
    check("defaults", outs, exp); // Group levels
    check("oe", 8'(oe), 8'h01); // Enabled
    check("standby", 8'(standby), 8'h01); // Idle
    $display("powerup test done");
  endtask
  task automatic t_addr_all();
    logic [7:0] d;
    logic       aa, da;
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        hi_tie = ioe_pad_class_t'(2'(h));
        lo_tie = ioe_pad_class_t'(2'(l));
        d = {4'(h * 4 + l), ~4'(h * 4 + l)};
        write1({3'h5, 2'(hi_tie), lo_bits(lo_tie)}, d, aa, da);
        check("addr ack", 8'(aa), 8'h01); // New address
        check("data ack", 8'(da), 8'h01); // Byte taken
        check("outputs", outs, d); // Bit order
        check("standby", 8'(standby), 8'h01); // Idle again
      end
    end
    $display("address test done");
  endtask
  task automatic t_wrong_addr();
    logic aa, da;
    hi_tie = ioe_pad_gnd;
    lo_tie = ioe_pad_gnd;
    write1(7'h68, 8'h33, aa, da);
    check("ack 110", 8'(aa), 8'h00); // Fixed bits differ
    write1(7'h18, 8'h33, aa, da);
    check("ack 001", 8'(aa), 8'h00); // Fixed bits differ
    check("outputs", outs, 8'hF0); // Unchanged
    $display("wrong address test done");
  endtask
  task automatic t_multi_write();
    logic aa;
    hi_tie = ioe_pad_vplus;
    lo_tie = ioe_pad_vplus;
    ioe_i2c_master_inst.bus_start();
    ioe_i2c_master_inst.put_byte(8'hBA, aa);
    ioe_i2c_master_inst.put_byte(8'h81, aa);
    tick(8);
    check("first byte", outs, 8'h81); // All eight at once
    ioe_i2c_master_inst.put_byte(8'h7E, aa);
    tick(8);
    check("second byte", outs, 8'h7E); // Again per byte
    check("second ack", 8'(aa), 8'h01); // Second data byte acked
    ioe_i2c_master_inst.bus_stop();
    $display("multi write test done");
  endtask
  task automatic t_read();
    logic       aa;
    logic [7:0] b;
    pin_force_en = 1'b1;
    pin_force = 8'hC3;
    ioe_i2c_master_inst.bus_start();
    ioe_i2c_master_inst.put_byte(8'hBB, aa);
    check("read ack", 8'(aa), 8'h01); // Address taken
    pin_force = 8'h3C;
    ioe_i2c_master_inst.get_byte(1'b1, b);
    check("read one", b, 8'hC3); // Pins, not register
    ioe_i2c_master_inst.get_byte(1'b0, b);
    check("read two", b, 8'h3C); // Fresh sample
    ioe_i2c_master_inst.bus_stop();
    pin_force_en = 1'b0;
    $display("read test done");
  endtask
  task automatic t_clear();
    logic r, aa, da;
    ioe_i2c_master_inst.bus_start();
    for (int i = 7; i >= 0; i--)
      ioe_i2c_master_inst.send_bit(1'(8'hBA >> i), r);
    tick(2);
    check("ack drive", 8'(sda_oe), 8'h01); // Acking 0xBA
    bus_clear_n = 1'b0;
    tick(6);
    check("released", 8'(sda_oe), 8'h00); // Abandoned
    check("idle", 8'(standby), 8'h01); // Back to idle
    check("kept", outs, 8'h7E); // Register kept
    check("oe kept", 8'(oe), 8'h01); // Drive kept
    bus_clear_n = 1'b1;
    tick(4);
    ioe_i2c_master_inst.send_bit(1'b1, r);
    ioe_i2c_master_inst.put_byte(8'h00, aa);
    check("no ack", 8'(aa), 8'h00); // Waits for a new start
    ioe_i2c_master_inst.bus_stop();
    write1(7'h5D, 8'h5A, aa, da);
    check("recovered", outs, 8'h5A); // Works after clear
    $display("bus clear test done");
  endtask

  // ==========================================================
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    bus_clear_n = 1'b1;
    pin_force_en = 1'b0;
    t_powerup(ioe_pad_gnd, ioe_pad_vplus, 8'h0F);
    t_powerup(ioe_pad_sda, ioe_pad_scl, 8'hFF);
    t_powerup(ioe_pad_vplus, ioe_pad_gnd, 8'hF0);
    t_addr_all();
    t_wrong_addr();
    t_multi_write();
    t_read();
    t_clear();
    complete_run();
  end
endmodule

bind ioe_expander ioe_expander_sva ioe_expander_sva_inst (.*);
